// [hdl/acd_byte_rx.sv]
`default_nettype none
`include "acd_params.svh"
module acd_byte_rx (
  // system
  input wire logic clock,
  input wire logic reset,
  // serial pins, asynchronous to clock
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  // assembled bytes
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic frame_open
);
  logic [1:0] sclk_s_r; // sync chain
  logic [1:0] cs_s_r; // sync chain
  logic [1:0] din_s_r; // sync chain
  logic sclk_d_r; // previous synced clock
  logic [2:0] bit_cnt_r; // bits in current byte
  logic [6:0] shift_r; // bits gathered so far
  logic valid_r;
  logic [7:0] data_r;
  logic open_r;
  // named decode of the synced pins
  wire active = ~cs_s_r[1];
  wire rise = sclk_s_r[1] & ~sclk_d_r;
  wire last_bit = (bit_cnt_r == 3'h7);
  // two flops per pin, only the second reads the first
  always_ff @(posedge clock) begin
    if (reset) begin
      sclk_s_r <= 2'h0;
      cs_s_r <= 2'h3;
      din_s_r <= 2'h0;
      sclk_d_r <= 1'b0;
    end else begin
      sclk_s_r <= {sclk_s_r[0], sclk};
      cs_s_r <= {cs_s_r[0], cs_n};
      din_s_r <= {din_s_r[0], din};
      sclk_d_r <= sclk_s_r[1];
    end
  end
  always_ff @(posedge clock) begin
    if (reset || !active) begin
      bit_cnt_r <= 3'h0;
      shift_r <= 7'h00;
    end else if (rise) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      shift_r <= {shift_r[5:0], din_s_r[1]};
    end
  end
  // msb first, byte ready on the eighth rising edge
  always_ff @(posedge clock) begin
    if (reset) begin
      valid_r <= 1'b0;
      data_r <= 8'h00;
      open_r <= 1'b0;
    end else begin
      valid_r <= active & rise & last_bit;
      if (active && rise && last_bit) begin
        data_r <= {shift_r, din_s_r[1]};
      end
      open_r <= active;
    end
  end
  assign byte_valid = valid_r;
  assign byte_data = data_r;
  assign frame_open = open_r;
endmodule : acd_byte_rx
`default_nettype wire

// [hdl/acd_cmd_decoder.sv]
`default_nettype none
`include "acd_params.svh"
module acd_cmd_decoder #(
  parameter int TCONV_CYC = 100, // conversion part of one sample
  parameter int REF_WAKE_CYC = 6500 // internal reference wake time
) (
  // system
  input wire logic clock,
  input wire logic reset,
  // serial port pins
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_din,
  // conversion start pin, active low
  input wire logic conv_start_pin_n,
  // requests to the converter
  output logic conv_req,
  output acd_pkg::acd_conv_t conv_sel,
  output logic result_done,
  output logic fifo_clear,
  output logic scan_busy,
  // register contents
  output logic [7:0] cfg_conv,
  output logic [7:0] cfg_setup,
  output logic [7:0] cfg_avg,
  output logic [7:0] cfg_uni,
  output logic [7:0] cfg_bip
);
  // per-sample time, acquisition rounded up
  localparam int TACQ_CYC = (`ACD_TACQ_NS + `ACD_CLK_NS - 1) / `ACD_CLK_NS;
  localparam int SAMPLE_CYC = TACQ_CYC + TCONV_CYC;

  logic rx_valid; // assembled byte strobe
  logic [7:0] rx_data;
  logic rx_open; // synced select low
  acd_byte_rx u_rx (
    .clock(clock),
    .reset(reset),
    .sclk(spi_sclk),
    .cs_n(spi_cs_n),
    .din(spi_din),
    .byte_valid(rx_valid),
    .byte_data(rx_data),
    .frame_open(rx_open)
  );

  // registers
  logic [7:0] conv_r, setup_r, avg_r, uni_r, bip_r;
  logic pend_r; // pair byte expected next
  logic pend_bip_r; // pending byte goes to bipolar flags
  logic clr_r; // result store clear pulse
  // start pin sync and edge
  logic [1:0] cnv_s_r;
  logic cnv_d_r;
  // sequencer
  acd_pkg::acd_state_t state_r, state_nxt;
  logic [2:0] cur_r, last_r;
  logic [4:0] res_left_r;
  logic [5:0] samp_left_r;
  logic [15:0] timer_r;
  logic req_r, done_r;
  logic busy_r; // registered busy, so the output leaves a flop
  acd_pkg::acd_conv_t sel_r;

  // byte class decode
  wire cmd = rx_valid & ~pend_r;
  wire is_conv = cmd & rx_data[`ACD_CONV_BIT];
  wire is_setup = cmd & (rx_data[7:6] == 2'b01);
  wire is_avg = cmd & (rx_data[7:5] == 3'b001);
  wire is_rst = cmd & (rx_data[7:4] == 4'b0001);
  wire soft_rst = is_rst & ~rx_data[`ACD_RST_BIT];
  wire pair_wr = rx_valid & pend_r;

  // live configuration fields
  wire [1:0] clk_mode = setup_r[`ACD_CLK_HI:`ACD_CLK_LO];
  wire [1:0] ref_sel = setup_r[`ACD_REF_HI:`ACD_REF_LO];
  // a starting conversion byte is not stored yet when the scan loads its range
  wire [7:0] conv_now = is_conv ? rx_data : conv_r;
  wire [2:0] chan_n = conv_now[`ACD_CHAN_HI:`ACD_CHAN_LO];
  wire [1:0] sweep = conv_now[`ACD_SWEEP_HI:`ACD_SWEEP_LO];
  wire avg_on = avg_r[`ACD_AVG_EN] & (clk_mode != 2'b11);
  wire [1:0] avg_cnt = avg_r[`ACD_AVG_HI:`ACD_AVG_LO];
  wire [1:0] rep_cnt = avg_r[`ACD_REP_HI:`ACD_REP_LO];
  wire pin_start = ~clk_mode[1];
  wire ext_pace = (clk_mode == 2'b01) | (clk_mode == 2'b11);

  // inputs taken over by the start pin or negative reference
  wire start_used = pin_start;
  wire refn_used = (ref_sel == 2'b11);
  wire [7:0] res_mask = {start_used, refn_used, 6'h00};

  // pair flags, bit 7 of each flag byte is pair 0
  wire [3:0] pair_uni = {uni_r[4], uni_r[5], uni_r[6], uni_r[7]};
  wire [3:0] pair_bip = {bip_r[4], bip_r[5], bip_r[6], bip_r[7]};
  wire pair_on = pair_uni[cur_r[2:1]] | pair_bip[cur_r[2:1]];
  wire pair_bipolar = pair_bip[cur_r[2:1]] & ~pair_uni[cur_r[2:1]];
  wire pair_ok = ~cur_r[0] & ~res_mask[{cur_r[2:1], 1'b0}] & ~res_mask[{cur_r[2:1], 1'b1}];
  wire cur_ok = pair_on ? pair_ok : ~res_mask[cur_r];
  wire [3:0] next_ch = {1'b0, cur_r} + (pair_on ? 4'h2 : 4'h1);
  wire at_end = (next_ch > {1'b0, last_r});

  // samples per result, one in mode 11, any sweep
  wire [5:0] navg = avg_on ? (6'h04 << avg_cnt) : 6'h01;
  wire [2:0] rep_plus = {1'b0, rep_cnt} + 3'h1;
  wire [4:0] nres = (sweep == 2'b10 && clk_mode != 2'b11) ? {rep_plus, 2'b00} : 5'h01;
  // sweep ranges, mode 11 converts input N alone
  wire single = (clk_mode == 2'b11) | sweep[1];
  wire [2:0] first_ch = (!single && sweep == 2'b00) ? 3'h0 : chan_n;
  wire [2:0] top_ch = (!single && sweep == 2'b01) ? 3'h7 : chan_n;

  wire cnv_fall = ~cnv_s_r[1] & cnv_d_r;
  wire ser_start = is_conv & clk_mode[1];
  wire go = (state_r == acd_pkg::ACD_IDLE) & (ser_start | (pin_start & cnv_fall));
  // wake only for internal reference that sleeps
  wire need_wake = (ref_sel == 2'b00);
  wire trig = (clk_mode == 2'b11) ? rx_valid : cnv_fall;
  wire fire = (state_r == acd_pkg::ACD_RUN) & (timer_r == 16'h0000) & cur_ok;
  // reserved inputs are passed over while waiting for a trigger as well
  wire skip = ((state_r == acd_pkg::ACD_RUN) | (state_r == acd_pkg::ACD_TRIG)) & (timer_r == 16'h0000) & ~cur_ok;
  wire res_end = fire & (samp_left_r == 6'h01);
  wire ch_end = (res_end & (res_left_r == 5'h01)) | skip;

  // start pin sync, first flop read only by second
  always_ff @(posedge clock) begin
    if (reset) begin
      cnv_s_r <= 2'h3;
      cnv_d_r <= 1'b1;
    end else begin
      cnv_s_r <= {cnv_s_r[0], conv_start_pin_n};
      cnv_d_r <= cnv_s_r[1];
    end
  end

  always_ff @(posedge clock) begin
    if (reset || soft_rst) begin
      conv_r <= `ACD_ZERO_RESET;
      setup_r <= `ACD_SETUP_RESET;
      avg_r <= `ACD_ZERO_RESET;
      uni_r <= `ACD_ZERO_RESET;
      bip_r <= `ACD_ZERO_RESET;
    end else begin
      if (is_conv) begin
        conv_r <= rx_data;
      end
      if (is_setup) begin
        setup_r <= rx_data;
      end
      if (is_avg) begin
        avg_r <= rx_data;
      end
      if (pair_wr && !pend_bip_r) begin
        uni_r <= rx_data;
      end
      if (pair_wr && pend_bip_r) begin
        bip_r <= rx_data;
      end
    end
  end

  // only modes 10/11 expect a pair byte; frame end cancels it
  always_ff @(posedge clock) begin
    if (reset || !rx_open) begin
      pend_r <= 1'b0;
      pend_bip_r <= 1'b0;
    end else if (rx_valid) begin
      pend_r <= is_setup & rx_data[`ACD_PAIR_HI];
      pend_bip_r <= rx_data[`ACD_PAIR_LO];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      clr_r <= 1'b0;
    end else begin
      clr_r <= is_rst & rx_data[`ACD_RST_BIT];
    end
  end

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      acd_pkg::ACD_IDLE: if (go) state_nxt = need_wake ? acd_pkg::ACD_WAKE : acd_pkg::ACD_RUN;
      acd_pkg::ACD_WAKE: if (timer_r == 16'h0000) state_nxt = acd_pkg::ACD_RUN;
      acd_pkg::ACD_RUN: begin
        if (ch_end && at_end) begin
          state_nxt = acd_pkg::ACD_IDLE;
        end else if (fire && ext_pace) begin
          state_nxt = acd_pkg::ACD_TRIG;
        end
      end
      // a scan whose remaining inputs are all skipped ends without another trigger
      acd_pkg::ACD_TRIG: begin
        if (skip && at_end) begin
          state_nxt = acd_pkg::ACD_IDLE;
        end else if (trig) begin
          state_nxt = acd_pkg::ACD_RUN;
        end
      end
    endcase
  end

  // sample spacing timer and wake delay
  always_ff @(posedge clock) begin
    if (reset || soft_rst) begin
      state_r <= acd_pkg::ACD_IDLE;
      timer_r <= 16'h0000;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r <= (state_nxt != acd_pkg::ACD_IDLE);
      if (go && need_wake) begin
        timer_r <= 16'(REF_WAKE_CYC - 1);
      end else if (fire && !ext_pace) begin
        timer_r <= 16'(SAMPLE_CYC - 1);
      end else if (timer_r != 16'h0000) begin
        timer_r <= timer_r - 16'h0001;
      end
    end
  end

  // scan position and counters
  always_ff @(posedge clock) begin
    if (reset) begin
      cur_r <= 3'h0;
      last_r <= 3'h0;
      res_left_r <= 5'h00;
      samp_left_r <= 6'h00;
    end else if (go) begin
      cur_r <= first_ch;
      last_r <= top_ch;
      res_left_r <= nres;
      samp_left_r <= navg;
    end else if (ch_end) begin
      cur_r <= next_ch[2:0];
      res_left_r <= nres;
      samp_left_r <= navg;
    end else if (res_end) begin
      res_left_r <= res_left_r - 5'h01;
      samp_left_r <= navg;
    end else if (fire) begin
      samp_left_r <= samp_left_r - 6'h01;
    end
  end

  // output coding flag travels with the request
  always_ff @(posedge clock) begin
    if (reset) begin
      req_r <= 1'b0;
      done_r <= 1'b0;
      sel_r <= '0;
    end else begin
      req_r <= fire;
      done_r <= res_end;
      if (fire) begin
        sel_r <= '{chan: cur_r, diff: pair_on, twos_comp: pair_on & pair_bipolar};
      end
    end
  end

  assign conv_req = req_r;
  assign conv_sel = sel_r;
  assign result_done = done_r;
  assign fifo_clear = clr_r;
  assign scan_busy = busy_r;
  assign cfg_conv = conv_r;
  assign cfg_setup = setup_r;
  assign cfg_avg = avg_r;
  assign cfg_uni = uni_r;
  assign cfg_bip = bip_r;

  // a setup byte asking for a unipolar pair byte
  sequence s_pair_setup;
    is_setup && rx_data[`ACD_PAIR_HI] && !rx_data[`ACD_PAIR_LO];
  endsequence
  // the pair byte that follows it in the same frame
  sequence s_pair_byte;
    pair_wr && !pend_bip_r;
  endsequence

  a_conv_write: assert property (@(posedge clock) disable iff (reset)
    is_conv && !soft_rst |=> conv_r == $past(rx_data)) else $error("conversion byte not stored");
  a_setup_write: assert property (@(posedge clock) disable iff (reset)
    is_setup |=> setup_r == $past(rx_data)) else $error("setup byte not stored");
  a_avg_write: assert property (@(posedge clock) disable iff (reset)
    is_avg |=> avg_r == $past(rx_data) && conv_r == $past(conv_r)) else $error("averaging byte misrouted");
  a_soft_default: assert property (@(posedge clock) disable iff (reset)
    soft_rst |=> setup_r == `ACD_SETUP_RESET && conv_r == 8'h00 && !scan_busy) else $error("defaults not restored");
  a_fifo_clear: assert property (@(posedge clock) disable iff (reset)
    is_rst && rx_data[`ACD_RST_BIT] |=> fifo_clear && $stable(setup_r)) else $error("clear misbehaves");
  a_no_pair: assert property (@(posedge clock) disable iff (reset)
    is_setup && !rx_data[`ACD_PAIR_HI] |=> !pend_r) else $error("pair byte wrongly expected");
  a_skip_reserved: assert property (@(posedge clock) disable iff (reset)
    conv_req && !soft_rst |-> !(conv_sel.chan == `ACD_START_CH && start_used)) else $error("start pin converted");
  a_unipolar_wins: assert property (@(posedge clock) disable iff (reset)
    fire && pair_uni[cur_r[2:1]] |=> conv_req && !conv_sel.twos_comp) else $error("bipolar overrode unipolar");
  a_no_avg_sclk: assert property (@(posedge clock) disable iff (reset)
    fire && clk_mode == 2'b11 |=> result_done) else $error("averaging in mode 11");
  a_serial_start: assert property (@(posedge clock) disable iff (reset)
    go && ser_start |=> scan_busy) else $error("serial start lost");
  a_pair_armed: assert property (@(posedge clock) disable iff (reset)
    s_pair_setup |=> pend_r && !pend_bip_r) else $error("pair byte not expected");
  a_pair_lands: assert property (@(posedge clock) disable iff (reset)
    s_pair_byte |=> uni_r == $past(rx_data) && $stable(bip_r)) else $error("pair byte lost");
endmodule : acd_cmd_decoder
`default_nettype wire

// [hdl/acd_params.svh]
`ifndef ACD_PARAMS_SVH
`define ACD_PARAMS_SVH
// command byte field positions
`define ACD_CONV_BIT 7
`define ACD_CHAN_HI 5
`define ACD_CHAN_LO 3
`define ACD_SWEEP_HI 2
`define ACD_SWEEP_LO 1
`define ACD_CLK_HI 5
`define ACD_CLK_LO 4
`define ACD_REF_HI 3
`define ACD_REF_LO 2
`define ACD_PAIR_HI 1
`define ACD_PAIR_LO 0
`define ACD_AVG_EN 4
`define ACD_AVG_HI 3
`define ACD_AVG_LO 2
`define ACD_REP_HI 1
`define ACD_REP_LO 0
`define ACD_RST_BIT 3
// reset values
`define ACD_SETUP_RESET 8'h20
`define ACD_ZERO_RESET 8'h00
// inputs that double as start pin and negative reference
`define ACD_START_CH 3'h7
`define ACD_REFN_CH 3'h6
// timing
`define ACD_CLK_NS 10
`define ACD_TACQ_NS 1400
`endif

// [hdl/acd_pkg.sv]
`default_nettype none
package acd_pkg;
  // sequencer states, gray along idle-wake-run-trigger
  typedef enum logic [1:0] {
    ACD_IDLE = 2'b00,
    ACD_WAKE = 2'b01,
    ACD_RUN = 2'b11,
    ACD_TRIG = 2'b10
  } acd_state_t;
  // one conversion request handed to the converter
  typedef struct packed {
    logic [2:0] chan;
    logic diff;
    logic twos_comp;
  } acd_conv_t;
endpackage : acd_pkg
`default_nettype wire

// [test/acd_cmd_decoder_tb.sv]
`default_nettype none
module acd_cmd_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // shortened counts keep the run brief
  localparam int WAKE = 20;
  localparam int TCONV = 5;
  // spacing of internally timed samples
  localparam int SAMPLE = 140 + TCONV;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic conv_start_pin_n = 1'b1;
  wire logic sclk, cs_n, din;
  logic conv_req, result_done, fifo_clear, scan_busy;
  acd_pkg::acd_conv_t conv_sel;
  logic [7:0] cfg_conv, cfg_setup, cfg_avg, cfg_uni, cfg_bip;
  int error_cnt = 0;
  int tests_run = 0;
  // monitor tallies and timestamps
  int cyc = 0, nreq = 0, nres = 0, nclr = 0, t_go = 0, t_req = 0, lat = 0, gap = 0;
  logic busy_d = 1'b0;
  acd_pkg::acd_conv_t got[$];

  acd_cmd_decoder #(.TCONV_CYC(TCONV), .REF_WAKE_CYC(WAKE)) u_acd_cmd_decoder (
    .clock(clock),
    .reset(reset),
    .spi_sclk(sclk),
    .spi_cs_n(cs_n),
    .spi_din(din),
    .conv_start_pin_n(conv_start_pin_n),
    .conv_req(conv_req),
    .conv_sel(conv_sel),
    .result_done(result_done),
    .fifo_clear(fifo_clear),
    .scan_busy(scan_busy),
    .cfg_conv(cfg_conv),
    .cfg_setup(cfg_setup),
    .cfg_avg(cfg_avg),
    .cfg_uni(cfg_uni),
    .cfg_bip(cfg_bip)
  );
  acd_spi_host u_acd_spi_host (
    .sclk(sclk),
    .cs_n(cs_n),
    .din(din)
  );

  // 100 MHz system clock
  initial begin
    forever #5 clock = ~clock;
  end

  // tally samples, results and clears; time first sample and spacing
  // sampled on the falling edge, where the design's outputs have settled
  always @(negedge clock) begin
    cyc++;
    if (scan_busy === 1'b1 && busy_d !== 1'b1) t_go = cyc;
    if (conv_req === 1'b1) begin
      if (nreq == 0) lat = cyc - t_go;
      gap = cyc - t_req;
      t_req = cyc;
      nreq++;
    end
    if (result_done === 1'b1) begin
      nres++;
      got.push_back(conv_sel);
    end
    if (fifo_clear === 1'b1) nclr++;
    busy_d = scan_busy;
  end

  task automatic conclude();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  // compare a register or captured field
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %0t value %h expected %h", $time, g, e);
    end
  endtask : chk

  // compare a bench count
  task automatic chkn(input int g, input int e);
    tests_run++;
    if (g != e) begin
      error_cnt++;
      $display("MISMATCH %0t count %0d expected %0d", $time, g, e);
    end
  endtask : chkn

  // bounded wait for the sequencer to go idle
  task automatic wait_idle();
    for (int i = 0; i < 20000 && scan_busy !== 1'b0; i++) @(negedge clock);
    // last result pulse and busy fall together; let the monitor tally it first
    @(negedge clock);
    chk({7'h00, scan_busy}, 8'h00);
  endtask : wait_idle

  // send a conversion byte and count what the scan produced
  task automatic scan(input logic [7:0] b, input int er, input int es);
    nreq = 0;
    nres = 0;
    got.delete();
    u_acd_spi_host.send8(b);
    wait_idle();
    chkn(nreq, er);
    chkn(nres, es);
  endtask : scan

  // low pulse on the start pin, long enough to pass the synchroniser
  task automatic pin();
    @(posedge clock);
    conv_start_pin_n <= 1'b0;
    repeat (4) @(posedge clock);
    conv_start_pin_n <= 1'b1;
    repeat (6) @(posedge clock);
  endtask : pin

  // hang guard, well past the expected run length
  initial begin
    repeat (80000) @(posedge clock);
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(negedge clock);
    chk(cfg_setup, 8'h20); // setup default
    chk(cfg_conv | cfg_avg | cfg_uni | cfg_bip, 8'h00); // others zero
    // a cut frame must not shift the next byte
    u_acd_spi_host.send4(4'h5);
    u_acd_spi_host.send8(8'h21);
    chk(cfg_avg, 8'h21); // byte realigned
    chk(cfg_setup, 8'h20); // no stray setup
    u_acd_spi_host.send16({8'h6a, 8'h80});
    u_acd_spi_host.send16({8'h6b, 8'hd0});
    chk(cfg_setup, 8'h6b); // setup stored
    chk(cfg_uni, 8'h80); // unipolar flags
    chk(cfg_bip, 8'hd0); // bipolar flags
    // pair codes 00 and 01: second byte is a fresh command
    for (int k = 0; k < 2; k++) begin
      u_acd_spi_host.send16({8'h68 + 8'(k), 8'h20 + 8'(k)});
      chk(cfg_avg, 8'h20 + 8'(k)); // averaging stored
      chk(cfg_uni | cfg_bip, 8'hd0); // pairs untouched
    end
    scan(8'ha6, 1, 1); // single input
    chk(8'(got[0]), 8'h10); // input four
    chkn(lat, 1); // no wake delay
    chk({3'h0, cfg_conv[5:1]}, 8'h13); // fields stored
    // pair 0/1 flagged twice, pair 2/3 bipolar, host names upper input
    scan(8'h98, 2, 2); // pairs counted once
    chk(8'(got[0]), 8'h02); // unipolar wins
    chk(8'(got[1]), 8'h0b); // bipolar two's complement
    scan(8'ha2, 3, 3); // upward sweep
    chk(8'(got[2]), 8'h1b); // pair by lower input
    u_acd_spi_host.send8(8'h6c);
    scan(8'ha2, 2, 2); // reference pin drops pair
    u_acd_spi_host.send8(8'h68);
    for (int k = 0; k < 4; k++) begin
      u_acd_spi_host.send8(8'h20 + 8'(k));
      scan(8'hac, 4 * (k + 1), 4 * (k + 1)); // repeat counts
      chkn(gap, SAMPLE); // sample spacing
    end
    for (int k = 0; k < 4; k++) begin
      u_acd_spi_host.send8(8'h30 + 8'(k * 4));
      scan(8'hae, 4 << k, 1); // averaging depth
    end
    u_acd_spi_host.send8(8'h78);
    scan(8'hae, 1, 1); // serial clock mode
    u_acd_spi_host.send8(8'h60);
    u_acd_spi_host.send8(8'h20);
    scan(8'hae, 1, 1); // reference wake
    chkn(lat, WAKE + 1); // wake length
    // pin start mode: serial write alone starts nothing
    u_acd_spi_host.send8(8'h48);
    nreq = 0;
    nres = 0;
    u_acd_spi_host.send8(8'hae);
    repeat (300) @(negedge clock);
    chkn(nreq, 0); // no serial start
    chk(cfg_conv, 8'hae); // still stored
    pin();
    wait_idle();
    chkn(nres, 1); // pin starts scan
    // one sample per pin pulse; pair 6/7 lost to the start pin
    u_acd_spi_host.send8(8'h58);
    u_acd_spi_host.send8(8'ha2);
    nreq = 0;
    pin();
    repeat (20) @(negedge clock);
    chkn(nreq, 1); // one per pulse
    pin();
    wait_idle();
    chkn(nreq, 2); // second pulse ends
    nclr = 0;
    u_acd_spi_host.send8(8'h18);
    chkn(nclr, 1); // store cleared
    chk(cfg_setup, 8'h58); // registers kept
    u_acd_spi_host.send8(8'h10);
    chk(cfg_setup, 8'h20); // defaults back
    chk(cfg_avg | cfg_bip | cfg_uni, 8'h00); // zeroed
    conclude();
  end
endmodule : acd_cmd_decoder_tb
`default_nettype wire

// [test/acd_spi_host.sv]
`default_nettype none
// host side of the serial port: frames command bytes msb first
module acd_spi_host (
  // serial pins toward the decoder
  output logic sclk,
  output logic cs_n,
  output logic din
);
  timeunit 1ns;
  timeprecision 1ns;
  // half of the 160 ns link clock
  localparam int HALF = 80;
  // idle pins: select high, clock parked low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // one frame of n bits; the 3 ns skew keeps edges off the system clock
  task automatic frame(input logic [15:0] d, input int n);
    #3;
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      din = d[i];
      #HALF;
      sclk = 1'b1;
      #HALF;
      sclk = 1'b0;
    end
    #HALF;
    cs_n = 1'b1;
    // released data line must not show a stale bit
    din = ~din;
    #(2 * HALF);
  endtask : frame
  task automatic send8(input logic [7:0] b);
    frame({8'h00, b}, 8);
  endtask : send8
  task automatic send16(input logic [15:0] w);
    frame(w, 16);
  endtask : send16
  task automatic send4(input logic [3:0] h);
    frame({12'h000, h}, 4);
  endtask : send4
endmodule : acd_spi_host
`default_nettype wire
